// file: include/ncosc_pkg.sv
// Purpose: shared constants and types of the numeric oscillator block
// Assumes: 32-bit classic Wishbone, byte-wide registers in bits 7:0
// Notes: one register per aligned word, unused bits read as zero
package ncosc_pkg;

    localparam int ACC_W = 20;
    localparam int NUM_SRC = 10;
    localparam int PCNT_W = 8;

    // register byte addresses
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] OFF_ACC_LOW = 8'h08;
    localparam logic [7:0] OFF_ACC_HIGH = 8'h0c;
    localparam logic [7:0] OFF_ACC_UPPER = 8'h10;
    localparam logic [7:0] OFF_STEP_LOW = 8'h14;
    localparam logic [7:0] OFF_STEP_HIGH = 8'h18;
    localparam logic [7:0] OFF_STEP_UPPER = 8'h1c;
    localparam logic [7:0] OFF_IRQ = 8'h20;

    // osc_control bits
    localparam int CTL_ENABLE = 7;
    localparam int CTL_OUT_STATE = 5;
    localparam int CTL_INVERT = 4;
    localparam int CTL_PULSE_MODE = 0;
    // osc_clock_select fields
    localparam int CLK_PWS_LO = 5;
    localparam int CLK_CKS_LO = 0;
    // irq register bits
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_ENABLE = 1;
    localparam int IRQ_PERIPH = 2;
    localparam int IRQ_GLOBAL = 3;

    // source clock codes
    localparam logic [3:0] CKS_SYSCLK = 4'h0;
    localparam logic [3:0] CKS_FAST_OSC = 4'h1;
    localparam logic [3:0] CKS_LAST = 4'ha;

    localparam logic [1:0] STEP_LOAD_EDGES = 2'h2;
    localparam logic [PCNT_W-1:0] PULSE_UNIT = 8'h01;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } ncosc_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } ncosc_wb_rsp_t;

    typedef struct packed {
        logic en;
        logic pol;
        logic pfm;
        logic [2:0] pws;
        logic [3:0] cks;
        logic [ACC_W-1:0] acc;
        logic [ACC_W-1:0] step;
        logic [ACC_W-1:0] shadow;
        logic [1:0] pend;
        logic raw;
        logic [PCNT_W-1:0] pcnt;
        logic flag;
        logic ie;
        logic peripheral_irq_enable;
        logic global_irq_enable;
        logic out;
        logic irq;
        logic keep;
        logic ack;
        logic [31:0] rdat;
    } ncosc_state_t;

    typedef struct packed {
        logic [NUM_SRC-1:0] sync1;
        logic [NUM_SRC-1:0] sync2;
        logic [NUM_SRC-1:0] last;
        logic edge_seen;
    } ncosc_edge_state_t;

    localparam ncosc_state_t RST_STATE = '0;
    localparam ncosc_edge_state_t RST_EDGE_STATE = '0;

endpackage

// file: rtl/ncosc_src_edge.sv
// Purpose: synchronise the source clocks and pick one rising-edge tick
// Assumes: source clocks are much slower than clk
// Notes: code zero ticks on every clk edge
`timescale 1ns/100ps
module ncosc_src_edge #(
    parameter int NSRC = ncosc_pkg::NUM_SRC
) (
    input wire logic clk, // system clock
    input wire logic reset_n, // synchronous reset, active low
    input wire logic [NSRC-1:0] src_clocks, // asynchronous clock pins
    input wire logic [3:0] cks, // selected source code
    output logic tick // one-cycle pulse per source edge
);
    ncosc_pkg::ncosc_edge_state_t s;
    ncosc_pkg::ncosc_edge_state_t next_s;
    logic [NSRC-1:0] rise;

    ////////////////////////////////////////////////////////////////////
    // per-source edge detect, only on the second sync stage
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gen_rise
            assign rise[g] = s.sync2[g] & ~s.last[g];
        end
    endgenerate

    always_comb begin
        next_s = s;
        next_s.sync1 = src_clocks;
        next_s.sync2 = s.sync1;
        next_s.last = s.sync2;
        if (cks == ncosc_pkg::CKS_SYSCLK) begin
            next_s.edge_seen = 1'b1;
        end else if (cks <= ncosc_pkg::CKS_LAST) begin
            next_s.edge_seen = rise[4'(cks - 4'h1)];
        end else begin
            // reserved codes deliver no edges at all
            next_s.edge_seen = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= ncosc_pkg::RST_EDGE_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.edge_seen;
endmodule

// file: rtl/ncosc_top.sv
// Purpose: numerically controlled oscillator with Wishbone registers
// Assumes: classic Wishbone slave, 32-bit data, byte registers in bits 7:0
// Notes: the oscillator advances on ticks of the selected source clock
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module ncosc_top #(
    parameter int NSRC = ncosc_pkg::NUM_SRC
) (
    input wire logic clk, // system clock, 125 MHz
    input wire logic reset_n, // synchronous reset, active low
    input wire ncosc_pkg::ncosc_wb_req_t wb_req, // wishbone request
    output ncosc_pkg::ncosc_wb_rsp_t wb_rsp, // wishbone answer
    input wire logic [NSRC-1:0] src_clocks, // source clocks, codes 1..10
    output logic osc_output, // oscillator output to peripherals
    output logic irq_out, // gated overflow or polarity-change interrupt
    output logic fast_osc_keep // hold fast oscillator on in sleep
);
    ncosc_pkg::ncosc_state_t s;
    ncosc_pkg::ncosc_state_t next_s;
    logic tick;
    logic adv;
    logic carry;
    logic req;
    logic wr;
    logic [ncosc_pkg::ACC_W:0] sum;
    logic [7:0] wd;
    logic acc_wr;
    logic step_low_wr;
    logic step_wr;
    logic pol_change;
    logic flag_clear;
    logic [7:0] rd;

    ncosc_src_edge #(
        .NSRC(NSRC)
    ) u_src_edge (
        .clk(clk),
        .reset_n(reset_n),
        .src_clocks(src_clocks),
        .cks(s.cks),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // bus decode; a write lands on the edge where ack is seen high
    assign req = wb_req.cyc & wb_req.stb;
    assign wr = req & wb_req.we & s.ack & wb_req.sel[0];
    assign wd = wb_req.dat[7:0];
    assign acc_wr = wr & ((wb_req.adr[7:2] == ncosc_pkg::OFF_ACC_LOW[7:2])
        | (wb_req.adr[7:2] == ncosc_pkg::OFF_ACC_HIGH[7:2])
        | (wb_req.adr[7:2] == ncosc_pkg::OFF_ACC_UPPER[7:2]));
    assign step_low_wr = wr
        & (wb_req.adr[7:2] == ncosc_pkg::OFF_STEP_LOW[7:2]);
    assign step_wr = step_low_wr | (wr
        & ((wb_req.adr[7:2] == ncosc_pkg::OFF_STEP_HIGH[7:2])
        | (wb_req.adr[7:2] == ncosc_pkg::OFF_STEP_UPPER[7:2])));
    assign pol_change = wr
        & (wb_req.adr[7:2] == ncosc_pkg::OFF_CONTROL[7:2])
        & (wd[ncosc_pkg::CTL_INVERT] != s.pol);
    assign flag_clear = wr & (wb_req.adr[7:2] == ncosc_pkg::OFF_IRQ[7:2])
        & ~wd[ncosc_pkg::IRQ_FLAG];

    ////////////////////////////////////////////////////////////////////
    // datapath
    assign adv = tick & s.en & (s.cks <= ncosc_pkg::CKS_LAST);
    assign sum = {1'b0, s.acc} + {1'b0, s.shadow};
    assign carry = adv & sum[ncosc_pkg::ACC_W];

    // read mux
    always_comb begin
        rd = 8'h00;
        unique case (wb_req.adr[7:2])
            ncosc_pkg::OFF_CONTROL[7:2]: begin
                rd[ncosc_pkg::CTL_ENABLE] = s.en;
                rd[ncosc_pkg::CTL_OUT_STATE] = s.out;
                rd[ncosc_pkg::CTL_INVERT] = s.pol;
                rd[ncosc_pkg::CTL_PULSE_MODE] = s.pfm;
            end
            ncosc_pkg::OFF_CLOCK_SELECT[7:2]: begin
                rd = {s.pws, 1'b0, s.cks};
            end
            ncosc_pkg::OFF_ACC_LOW[7:2]: begin
                rd = s.acc[7:0];
            end
            ncosc_pkg::OFF_ACC_HIGH[7:2]: begin
                rd = s.acc[15:8];
            end
            ncosc_pkg::OFF_ACC_UPPER[7:2]: begin
                rd = {4'h0, s.acc[19:16]};
            end
            ncosc_pkg::OFF_STEP_LOW[7:2]: begin
                rd = s.step[7:0];
            end
            ncosc_pkg::OFF_STEP_HIGH[7:2]: begin
                rd = s.step[15:8];
            end
            ncosc_pkg::OFF_STEP_UPPER[7:2]: begin
                rd = {4'h0, s.step[19:16]};
            end
            ncosc_pkg::OFF_IRQ[7:2]: begin
                rd = {4'h0, s.global_irq_enable, s.peripheral_irq_enable, s.ie, s.flag};
            end
            default: begin
                rd = 8'h00;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        next_s.ack = req & ~s.ack;
        next_s.rdat = (req & ~s.ack) ? {24'h00_0000, rd} : 32'h0000_0000;

        // accumulator advances only on an admitted source tick
        if (adv) begin
            next_s.acc = sum[ncosc_pkg::ACC_W-1:0];
        end

        // shadow step: immediate when stopped, delayed when running
        if (!s.en) begin
            next_s.shadow = s.step;
            next_s.pend = 2'h0;
        end else if (adv && s.pend != 2'h0) begin
            next_s.pend = s.pend - 2'h1;
            if (s.pend == 2'h1) begin
                next_s.shadow = s.step;
            end
        end

        // output shaping
        if (!s.en) begin
            next_s.raw = 1'b0;
            next_s.pcnt = '0;
        end else if (adv) begin
            if (s.pfm) begin
                if (carry) begin
                    // retrigger keeps a long pulse from ever dropping
                    next_s.raw = 1'b1;
                    next_s.pcnt = ncosc_pkg::PULSE_UNIT << s.pws;
                end else if (s.raw) begin
                    if (s.pcnt <= ncosc_pkg::PULSE_UNIT) begin
                        next_s.raw = 1'b0;
                        next_s.pcnt = '0;
                    end else begin
                        next_s.pcnt = s.pcnt - ncosc_pkg::PULSE_UNIT;
                    end
                end
            end else if (carry) begin
                next_s.raw = ~s.raw;
            end
        end

        // register writes
        if (wr) begin
            unique case (wb_req.adr[7:2])
                ncosc_pkg::OFF_CONTROL[7:2]: begin
                    next_s.en = wd[ncosc_pkg::CTL_ENABLE];
                    next_s.pol = wd[ncosc_pkg::CTL_INVERT];
                    next_s.pfm = wd[ncosc_pkg::CTL_PULSE_MODE];
                end
                ncosc_pkg::OFF_CLOCK_SELECT[7:2]: begin
                    next_s.pws = wd[ncosc_pkg::CLK_PWS_LO +: 3];
                    next_s.cks = wd[ncosc_pkg::CLK_CKS_LO +: 4];
                end
                // undefined while running; the bus write simply wins
                ncosc_pkg::OFF_ACC_LOW[7:2]: begin
                    next_s.acc[7:0] = wd;
                end
                ncosc_pkg::OFF_ACC_HIGH[7:2]: begin
                    next_s.acc[15:8] = wd;
                end
                ncosc_pkg::OFF_ACC_UPPER[7:2]: begin
                    next_s.acc[19:16] = wd[3:0];
                end
                ncosc_pkg::OFF_STEP_LOW[7:2]: begin
                    next_s.step[7:0] = wd;
                    if (s.en) begin
                        // commits all three bytes
                        next_s.pend = ncosc_pkg::STEP_LOAD_EDGES;
                    end
                end
                ncosc_pkg::OFF_STEP_HIGH[7:2]: begin
                    next_s.step[15:8] = wd;
                end
                ncosc_pkg::OFF_STEP_UPPER[7:2]: begin
                    next_s.step[19:16] = wd[3:0];
                end
                ncosc_pkg::OFF_IRQ[7:2]: begin
                    next_s.ie = wd[ncosc_pkg::IRQ_ENABLE];
                    next_s.peripheral_irq_enable = wd[ncosc_pkg::IRQ_PERIPH];
                    next_s.global_irq_enable = wd[ncosc_pkg::IRQ_GLOBAL];
                end
                default: begin
                end
            endcase
        end

        // sticky flag: a set in the clearing cycle wins
        if (carry || (pol_change && s.ie)) begin
            next_s.flag = 1'b1;
        end else if (flag_clear) begin
            next_s.flag = 1'b0;
        end

        next_s.out = next_s.raw ^ next_s.pol;
        next_s.irq = next_s.flag & next_s.ie & next_s.peripheral_irq_enable & next_s.global_irq_enable
            & next_s.en;
        next_s.keep = next_s.en
            & (next_s.cks == ncosc_pkg::CKS_FAST_OSC);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= ncosc_pkg::RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign wb_rsp = '{ack: s.ack, dat: s.rdat};
    assign osc_output = s.out;
    assign irq_out = s.irq;
    assign fast_osc_keep = s.keep;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    chk_acc_adds: assert property (
        adv && !acc_wr |=> s.acc == $past(sum[ncosc_pkg::ACC_W-1:0]))
        else $error("accumulator did not add the shadow step");

    chk_carry_sets_flag: assert property (
        carry |=> s.flag ##1 (irq_out == (s.ie & s.peripheral_irq_enable & s.global_irq_enable & s.en)
            || !s.flag))
        else $error("overflow did not raise the flag or gate irq");

    chk_flag_sticky: assert property (
        s.flag && !flag_clear |=> s.flag)
        else $error("overflow flag dropped without a clear");

    chk_fdc_toggle: assert property (
        carry && !s.pfm |=> s.raw != $past(s.raw))
        else $error("fixed duty output did not toggle");

    chk_pulse_start: assert property (
        carry && s.pfm |=> s.raw
            ##1 (s.raw || !$past(s.en) || $past(s.pws, 2) == 3'h0))
        else $error("pulse did not go active after overflow");

    chk_pulse_one: assert property (
        carry && s.pfm && s.pws == 3'h0 && !wr
        |=> s.pcnt == ncosc_pkg::PULSE_UNIT)
        else $error("shortest pulse width not one period");

    chk_invert_out: assert property (
        $changed(s.pol) && $stable(s.raw) |-> s.out != $past(s.out))
        else $error("polarity change did not flip the output");

    chk_stopped_load: assert property (
        !s.en && !step_wr ##1 !s.en |-> s.shadow == $past(s.step))
        else $error("shadow not loaded while stopped");

    chk_step_pending: assert property (
        s.en && step_low_wr && !(adv && s.pend == 2'h1)
            |=> s.pend == 2'h2 && $stable(s.shadow))
        else $error("running low step write not deferred");

    chk_reserved_hold: assert property (
        s.cks > ncosc_pkg::CKS_LAST && !acc_wr |=> $stable(s.acc))
        else $error("accumulator moved on a reserved clock code");

    chk_pol_flag: assert property (
        pol_change && s.ie |=> s.flag)
        else $error("polarity change did not raise the flag");

    chk_flag_clear: assert property (
        flag_clear && !carry && !(pol_change && s.ie) |=> !s.flag)
        else $error("software clear did not drop the flag");

    chk_irq_gate: assert property (
        s.flag && s.ie && s.peripheral_irq_enable && s.global_irq_enable && s.en && !wr |=> irq_out)
        else $error("gated interrupt missing");

    chk_keep_fast: assert property (
        s.en && s.cks == ncosc_pkg::CKS_FAST_OSC && !wr |=> fast_osc_keep)
        else $error("fast oscillator not kept alive");

    chk_reset_clear: assert property (
        @(posedge clk) disable iff (1'b0)
        !reset_n |=> s == ncosc_pkg::RST_STATE)
        else $error("reset left a register set");

    chk_stopped_idle: assert property (
        !s.en |=> !s.raw && s.pcnt == '0)
        else $error("stopped oscillator output not idle");

    chk_stopped_hold: assert property (
        !s.en && !acc_wr |=> $stable(s.acc))
        else $error("stopped accumulator moved");

    chk_fdc_hold: assert property (
        adv && !carry && !s.pfm |=> $stable(s.raw))
        else $error("fixed duty output moved without overflow");

    chk_pulse_end: assert property (
        adv && s.pfm && s.raw && !carry
            && s.pcnt == ncosc_pkg::PULSE_UNIT |=> !s.raw)
        else $error("pulse outlived its width");

    chk_step_commit: assert property (
        adv && s.pend == 2'h1 |=> s.shadow == $past(s.step))
        else $error("running step not committed on second edge");

    chk_bus_ack: assert property (
        req && !s.ack |=> wb_rsp.ack ##1 !wb_rsp.ack)
        else $error("bus ack not a one-cycle answer");

    cov_pulse_overflow: cover property (carry && s.pfm);
    cov_fdc_overflow: cover property (carry && !s.pfm);
    cov_pol_irq: cover property (pol_change && s.ie);
    cov_step_commit: cover property (adv && s.pend == 2'h1);
    cov_reserved_code: cover property (s.en && s.cks > ncosc_pkg::CKS_LAST);
endmodule

// file: dv/ncosc_tb.sv
// Purpose: self-checking bench of the numeric oscillator block
// Assumes: clock code 0 ticks once per clk, so widths count in clk cycles
// Notes: source code 1 is pulsed by hand so the tick count is exact
`timescale 1ns/100ps
module tb;
    logic clk;
    logic reset_n;
    ncosc_pkg::ncosc_wb_req_t wb_req;
    ncosc_pkg::ncosc_wb_rsp_t wb_rsp;
    logic [ncosc_pkg::NUM_SRC-1:0] src_clocks;
    logic osc_output;
    logic irq_out;
    logic fast_osc_keep;
    int n_errors;
    int total_checks;
    logic [7:0] rv;
    int rises;
    int highs;
    int len;
    int pw;

    ncosc_top DUT (
        .clk(clk),
        .reset_n(reset_n),
        .wb_req(wb_req),
        .wb_rsp(wb_rsp),
        .src_clocks(src_clocks),
        .osc_output(osc_output),
        .irq_out(irq_out),
        .fast_osc_keep(fast_osc_keep)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // classic cycle; ack and data are taken at the same edge
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h00_0000, wd}};
        do @(posedge clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat[7:0];
        wb_req.cyc <= 1'b0;
        wb_req.stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] dummy;
        xfer(1'b1, adr, d, dummy);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [7:0] e);
        xfer(1'b0, adr, 8'h00, rv);
        check(32'(rv), 32'(e));
    endtask

    // upper byte first: the low byte commits the value while running
    task automatic set_step(input logic [19:0] v);
        wr(ncosc_pkg::OFF_STEP_UPPER, {4'h0, v[19:16]});
        wr(ncosc_pkg::OFF_STEP_HIGH, v[15:8]);
        wr(ncosc_pkg::OFF_STEP_LOW, v[7:0]);
    endtask

    task automatic watch(input int cycles);
        logic prev;
        prev = osc_output;
        rises = 0;
        highs = 0;
        repeat (cycles) begin
            @(posedge clk);
            if (osc_output === 1'b1 && prev === 1'b0) rises++;
            if (osc_output === 1'b1) highs++;
            prev = osc_output;
        end
    endtask

    task automatic pulse_len(output int n);
        logic prev;
        prev = 1'b1;
        n = 0;
        while (!(osc_output === 1'b1 && prev === 1'b0)) begin
            prev = osc_output;
            @(posedge clk);
        end
        while (osc_output === 1'b1) begin
            n++;
            @(posedge clk);
        end
    endtask

    // slow enough for the two-flop synchroniser to see every edge
    task automatic src_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            src_clocks[0] <= 1'b1;
            repeat (4) @(posedge clk);
            src_clocks[0] <= 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial begin
        reset_n = 1'b0;
        wb_req = '0;
        src_clocks = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        // every register, plus one unmapped word, reads zero
        for (int a = 0; a <= 36; a += 4) begin
            rdc(8'(a), 8'h00);
        end
        check(32'(osc_output), 32'h0000_0000);
        check(32'(irq_out), 32'h0000_0000);
        wr(ncosc_pkg::OFF_ACC_UPPER, 8'hf5);
        wr(ncosc_pkg::OFF_ACC_HIGH, 8'ha3);
        wr(ncosc_pkg::OFF_ACC_LOW, 8'h71);
        rdc(ncosc_pkg::OFF_ACC_UPPER, 8'h05);
        rdc(ncosc_pkg::OFF_ACC_HIGH, 8'ha3);
        rdc(ncosc_pkg::OFF_ACC_LOW, 8'h71);
        set_step(20'h3_5c2e);
        wr(ncosc_pkg::OFF_STEP_UPPER, 8'hf3);
        rdc(ncosc_pkg::OFF_STEP_UPPER, 8'h03);
        rdc(ncosc_pkg::OFF_STEP_HIGH, 8'h5c);
        rdc(ncosc_pkg::OFF_STEP_LOW, 8'h2e);
        wr(8'h24, 8'hff);
        rdc(8'h24, 8'h00);
        wr(ncosc_pkg::OFF_CONTROL, 8'h7f);
        rdc(ncosc_pkg::OFF_CONTROL, 8'h31);
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);
        wr(ncosc_pkg::OFF_CLOCK_SELECT, 8'hff);
        rdc(ncosc_pkg::OFF_CLOCK_SELECT, 8'hef);
        wr(ncosc_pkg::OFF_CLOCK_SELECT, 8'h00);

        // fixed duty: step of a quarter wraps every 4 ticks
        set_step(20'h4_0000);
        wr(ncosc_pkg::OFF_IRQ, 8'h0e);
        wr(ncosc_pkg::OFF_CONTROL, 8'h80);
        watch(40);
        check(32'(rises), 32'h0000_0005);
        check(32'(highs), 32'h0000_0014);
        check(32'(irq_out), 32'h0000_0001);
        // upper byte alone must not reach the adder
        wr(ncosc_pkg::OFF_STEP_UPPER, 8'h08);
        watch(40);
        check(32'(rises), 32'h0000_0005);
        wr(ncosc_pkg::OFF_STEP_LOW, 8'h00);
        repeat (8) @(posedge clk);
        watch(40);
        check(32'(rises), 32'h0000_000a);
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        check(32'(irq_out), 32'h0000_0000);
        rdc(ncosc_pkg::OFF_IRQ, 8'h0f);
        wr(ncosc_pkg::OFF_IRQ, 8'h0e);
        rdc(ncosc_pkg::OFF_IRQ, 8'h0e);
        wr(ncosc_pkg::OFF_CONTROL, 8'h10);
        rdc(ncosc_pkg::OFF_IRQ, 8'h0f);
        check(32'(osc_output), 32'h0000_0001);
        rdc(ncosc_pkg::OFF_CONTROL, 8'h30);
        wr(ncosc_pkg::OFF_IRQ, 8'h00);
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);

        // pulse widths 1, 2, 4, 8 and 128 clk at one tick per clk
        for (int k = 0; k < 5; k++) begin
            pw = (k < 4) ? k : 7;
            wr(ncosc_pkg::OFF_CONTROL, 8'h00);
            set_step((k < 4) ? 20'h1_0000 : 20'h0_1000);
            wr(ncosc_pkg::OFF_CLOCK_SELECT, 8'(pw << 5));
            wr(ncosc_pkg::OFF_CONTROL, 8'h81);
            pulse_len(len);
            check(32'(len), 32'(1 << pw));
        end
        // 128-tick width against a 16-tick overflow interval
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);
        set_step(20'h1_0000);
        wr(ncosc_pkg::OFF_CLOCK_SELECT, 8'he0);
        wr(ncosc_pkg::OFF_CONTROL, 8'h81);
        repeat (140) @(posedge clk);
        watch(200);
        check(32'(rises), 32'h0000_0000);
        check(32'(highs), 32'h0000_00c8);
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);

        // reserved code gives no ticks; code 1 counts hand-made edges
        wr(ncosc_pkg::OFF_ACC_UPPER, 8'h00);
        wr(ncosc_pkg::OFF_ACC_HIGH, 8'h00);
        wr(ncosc_pkg::OFF_ACC_LOW, 8'h10);
        set_step(20'h0_0003);
        wr(ncosc_pkg::OFF_CLOCK_SELECT, 8'h0b);
        wr(ncosc_pkg::OFF_CONTROL, 8'h80);
        repeat (10) @(posedge clk);
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);
        rdc(ncosc_pkg::OFF_ACC_LOW, 8'h10);
        rdc(ncosc_pkg::OFF_ACC_UPPER, 8'h00);
        wr(ncosc_pkg::OFF_CLOCK_SELECT, 8'h01);
        wr(ncosc_pkg::OFF_CONTROL, 8'h80);
        repeat (2) @(posedge clk);
        check(32'(fast_osc_keep), 32'h0000_0001);
        src_pulses(5);
        repeat (8) @(posedge clk);
        wr(ncosc_pkg::OFF_CONTROL, 8'h00);
        rdc(ncosc_pkg::OFF_ACC_LOW, 8'h1f);
        repeat (2) @(posedge clk);
        check(32'(fast_osc_keep), 32'h0000_0000);
        test_done();
    end
endmodule
